// ===== gocp_pkg.sv
// gain/offset correction: shared constants and types
// assumes: single 100 MHz clock pclk, async active-low presetn
package gocp_pkg;
    localparam int unsigned N_BITS = 16;
    localparam int unsigned N_CH = 2;
    localparam int unsigned N_DAC = 4;
    localparam int unsigned N_SEL = 2;
    localparam int unsigned N_PAIR = N_CH * N_DAC * N_SEL;
    localparam logic [15:0] GAIN_RST = 16'hFFFF;
    localparam logic [15:0] OFFS_RST = 16'h8000;
    localparam logic [17:0] HALF_SCALE = 18'h08000;
    localparam logic [17:0] SAT_MAX = 18'h0FFFF;
    localparam logic [2:0] LOAD_DELAY = 3'h4;
    // apb register map (word offsets in bytes)
    localparam logic [11:0] A_CTRL = 12'h000;   // [0] correction enable, [1] mode select
    localparam logic [11:0] A_CMD = 12'h004;    // [1:0] op, [3:2] dac, [5:4] ch mask, [6] sel
    localparam logic [11:0] A_DATA = 12'h008;   // [15:0] word to send
    localparam logic [11:0] A_STAT = 12'h00C;   // [0] busy, [1] load seen
    localparam logic [11:0] A_RDATA = 12'h010;  // [15:0] read-back word
    typedef enum logic [1:0] {GOCP_OP_DATA, GOCP_OP_GAIN, GOCP_OP_OFFS, GOCP_OP_READ} gocp_op_e;
    localparam logic [15:0] CTRL_RST = 16'h0001;
endpackage

// ===== gocp_if.sv
// link between host end and correction device end
// assumes: both ends clocked by the same pclk
`timescale 1ns/10ps
`default_nettype none
interface gocp_if;
    logic wr_stb;
    logic [1:0] op;
    logic [1:0] dac;
    logic [1:0] ch_mask;
    logic sel;
    logic [15:0] wdata;
    logic rd_stb;
    logic frame_end;
    logic busy;
    logic [15:0] rdata;
    logic rvalid;
    logic load_pulse;
    logic [1:0] load_ch;
    modport host (output wr_stb, op, dac, ch_mask, sel, wdata, rd_stb, frame_end,
                  input busy, rdata, rvalid, load_pulse, load_ch);
    modport dev (input wr_stb, op, dac, ch_mask, sel, wdata, rd_stb, frame_end,
                 output busy, rdata, rvalid, load_pulse, load_ch);
endinterface
`default_nettype wire

// ===== gocp_calc.sv
// correction arithmetic: gain multiply, offset add, saturation
// assumes: purely combinational, used by the device end
`timescale 1ns/10ps
`default_nettype none
module gocp_calc (
    input wire logic [15:0] input_word,
    input wire logic [15:0] gain,
    input wire logic [15:0] offs,
    input wire logic enable,
    output logic [15:0] corrected_word
);
    logic [32:0] prod;
    logic [17:0] sum;
    // (m+1)*x >> 16, fraction dropped
    assign prod = ({17'h00000, input_word} * {16'h0000, {1'b0, gain} + 17'h00001}) ;
    // offset in raw steps, not scaled by gain
    assign sum = {1'b0, prod[32:16]} + {2'h0, offs} - gocp_pkg::HALF_SCALE;
    assign corrected_word = !enable ? input_word :
                            sum[17] ? 16'h0000 :
                            (sum > gocp_pkg::SAT_MAX) ? 16'hFFFF : sum[15:0];
endmodule
`default_nettype wire

// ===== gocp_dev.sv
// device end: coefficient storage, corrected-word registers, load timing
// assumes: host end drives the link on the same pclk
`timescale 1ns/10ps
`default_nettype none
module gocp_dev (
    input wire logic pclk,
    input wire logic presetn,
    gocp_if.dev lnk,
    input wire logic cal_enable,
    input wire logic mode_sel,
    output logic [15:0] dac_word [gocp_pkg::N_CH*gocp_pkg::N_DAC],
    output logic dac_load,
    output logic [1:0] dac_load_ch
);
    localparam int unsigned NW = gocp_pkg::N_CH * gocp_pkg::N_DAC;
    function automatic logic [3:0] pidx(input logic ch, input logic [1:0] d, input logic s);
        pidx = {ch, d, s};
    endfunction
    logic [15:0] gain_q [gocp_pkg::N_PAIR];
    logic [15:0] offs_q [gocp_pkg::N_PAIR];
    logic [15:0] x2_q [NW];
    logic [15:0] x1_q;
    logic [1:0] dac_q;
    logic [1:0] pend_q;
    logic ch_q;
    logic busy_q;
    logic [1:0] loaded_q;
    logic [2:0] dly_q;
    logic dly_run_q;
    logic load_q;
    logic [1:0] load_ch_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic [15:0] calc_out;
    logic [3:0] cur_idx;
    logic [3:0] wr_idx;
    logic [2:0] rd_idx;
    logic data_wr;
    logic coef_wr;
    // pair chosen by mode in force when the data write runs
    assign cur_idx = pidx(ch_q, dac_q, mode_sel);
    assign wr_idx = pidx(lnk.ch_mask[0] ? 1'b0 : 1'b1, lnk.dac, lnk.sel);
    assign rd_idx = {lnk.ch_mask[1] & ~lnk.ch_mask[0], lnk.dac};
    assign data_wr = lnk.wr_stb && lnk.op == gocp_pkg::GOCP_OP_DATA && !busy_q && lnk.ch_mask != 2'h0;
    assign coef_wr = lnk.wr_stb && (lnk.op == gocp_pkg::GOCP_OP_GAIN || lnk.op == gocp_pkg::GOCP_OP_OFFS);
    gocp_calc u_calc (
        .input_word(x1_q),
        .gain(gain_q[cur_idx]),
        .offs(offs_q[cur_idx]),
        .enable(cal_enable),
        .corrected_word(calc_out)
    );
    genvar gi;
    generate
        for (gi = 0; gi < gocp_pkg::N_PAIR; gi++) begin : g_coef
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gain_q[gi] <= gocp_pkg::GAIN_RST;
                    offs_q[gi] <= gocp_pkg::OFFS_RST;
                end else if (coef_wr && wr_idx == 4'(gi)) begin
                    // stored corrected words left alone
                    if (lnk.op == gocp_pkg::GOCP_OP_GAIN) begin
                        gain_q[gi] <= lnk.wdata;
                    end else begin
                        offs_q[gi] <= lnk.wdata;
                    end
                end
            end
        end
        for (gi = 0; gi < NW; gi++) begin : g_x2
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    x2_q[gi] <= 16'h0000;
                end else if (busy_q && {ch_q, dac_q} == 3'(gi)) begin
                    x2_q[gi] <= calc_out;
                end
            end
            assign dac_word[gi] = x2_q[gi];
        end
    endgenerate
    // sequencer: one channel per cycle on a dual write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x1_q <= 16'h0000;
            dac_q <= 2'h0;
            pend_q <= 2'h0;
            ch_q <= 1'b0;
            busy_q <= 1'b0;
            loaded_q <= 2'h0;
        end else if (data_wr) begin
            x1_q <= lnk.wdata;
            dac_q <= lnk.dac;
            ch_q <= ~lnk.ch_mask[0];
            pend_q <= lnk.ch_mask[0] ? {1'b0, lnk.ch_mask[1]} : 2'h0;
            busy_q <= 1'b1;
            loaded_q <= loaded_q | lnk.ch_mask;
        end else if (busy_q) begin
            if (pend_q[0]) begin
                ch_q <= 1'b1;
                pend_q <= 2'h0;
            end else begin
                busy_q <= 1'b0;
            end
        end else if (load_q) begin
            loaded_q <= 2'h0;
        end
    end
    // analog update four cycles after frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_q <= 3'h0;
            dly_run_q <= 1'b0;
            load_q <= 1'b0;
            load_ch_q <= 2'h0;
        end else begin
            load_q <= 1'b0;
            if (lnk.frame_end && loaded_q != 2'h0) begin
                dly_q <= 3'h1;
                dly_run_q <= 1'b1;
            end else if (dly_run_q) begin
                dly_q <= dly_q + 3'h1;
                if (dly_q == gocp_pkg::LOAD_DELAY - 3'h1) begin
                    dly_run_q <= 1'b0;
                    load_q <= 1'b1;
                    load_ch_q <= loaded_q;
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= lnk.rd_stb;
            if (lnk.rd_stb) begin
                rdata_q <= x2_q[rd_idx];
            end
        end
    end
    assign lnk.busy = busy_q;
    assign lnk.rdata = rdata_q;
    assign lnk.rvalid = rvalid_q;
    assign lnk.load_pulse = load_q;
    assign lnk.load_ch = load_ch_q;
    assign dac_load = load_q;
    assign dac_load_ch = load_ch_q;
endmodule
`default_nettype wire

// ===== gocp_host.sv
// host end: apb slave registers that issue link commands
// assumes: apb master on pclk; device end on the far side of the link
`timescale 1ns/10ps
`default_nettype none
module gocp_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    gocp_if.host lnk,
    output logic cal_enable,
    output logic mode_sel
);
    logic [15:0] ctrl_q;
    logic [15:0] data_q;
    logic [15:0] rb_q;
    logic load_seen_q;
    logic wr_q;
    logic rd_q;
    logic fe_q;
    logic [1:0] op_q;
    logic [1:0] dac_q;
    logic [1:0] chm_q;
    logic sel_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic acc;
    logic hit;
    logic cmd_go;
    assign acc = psel && penable;
    assign hit = paddr == gocp_pkg::A_CTRL || paddr == gocp_pkg::A_CMD || paddr == gocp_pkg::A_DATA ||
                 paddr == gocp_pkg::A_STAT || paddr == gocp_pkg::A_RDATA;
    // host forwards each command as written, dropping non-read ones while busy; it does not enforce a mode, coefficients, data order
    assign cmd_go = acc && pwrite && paddr == gocp_pkg::A_CMD;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= gocp_pkg::CTRL_RST;
            data_q <= 16'h0000;
            rb_q <= 16'h0000;
            load_seen_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            fe_q <= 1'b0;
            op_q <= 2'h0;
            dac_q <= 2'h0;
            chm_q <= 2'h0;
            sel_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            fe_q <= wr_q && op_q == gocp_pkg::GOCP_OP_DATA;
            wr_q <= cmd_go && pwdata[1:0] != gocp_pkg::GOCP_OP_READ && !lnk.busy;
            rd_q <= cmd_go && pwdata[1:0] == gocp_pkg::GOCP_OP_READ;
            if (cmd_go) begin
                op_q <= pwdata[1:0];
                dac_q <= pwdata[3:2];
                chm_q <= pwdata[5:4];
                sel_q <= pwdata[6];
            end
            if (acc && pwrite && paddr == gocp_pkg::A_CTRL) begin
                ctrl_q <= pwdata[15:0];
            end
            if (acc && pwrite && paddr == gocp_pkg::A_DATA) begin
                data_q <= pwdata[15:0];
            end
            if (lnk.rvalid) begin
                rb_q <= lnk.rdata;
            end
            // load event sets, status read clears; set wins
            if (lnk.load_pulse) begin
                load_seen_q <= 1'b1;
            end else if (acc && !pwrite && paddr == gocp_pkg::A_STAT) begin
                load_seen_q <= 1'b0;
            end
            pslverr_q <= psel && !penable && !(paddr == gocp_pkg::A_CTRL || hit);
            if (psel && !penable) begin
                case (paddr)
                    gocp_pkg::A_CTRL: prdata_q <= {16'h0000, ctrl_q};
                    gocp_pkg::A_DATA: prdata_q <= {16'h0000, data_q};
                    gocp_pkg::A_STAT: prdata_q <= {30'h00000000, load_seen_q, lnk.busy | wr_q};
                    gocp_pkg::A_RDATA: prdata_q <= {16'h0000, rb_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = 1'b1;
    // set at the setup edge, so it stands exactly in the access cycle
    assign pslverr = pslverr_q;
    assign cal_enable = ctrl_q[0];
    assign mode_sel = ctrl_q[1];
    assign lnk.wr_stb = wr_q;
    assign lnk.rd_stb = rd_q;
    assign lnk.frame_end = fe_q;
    assign lnk.op = op_q;
    assign lnk.dac = dac_q;
    assign lnk.ch_mask = chm_q;
    assign lnk.sel = sel_q;
    assign lnk.wdata = data_q;
endmodule
`default_nettype wire

// ===== gocp_link_sva.sv
// checker for the link between host end and device end
// assumes: instantiated beside the link interface, one clock pclk
`timescale 1ns/10ps
`default_nettype none
module gocp_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_stb,
    input wire logic [1:0] op,
    input wire logic [1:0] ch_mask,
    input wire logic rd_stb,
    input wire logic frame_end,
    input wire logic busy,
    input wire logic rvalid,
    input wire logic load_pulse,
    input wire logic [1:0] load_ch
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire data_go = wr_stb && (op == gocp_pkg::GOCP_OP_DATA) && !busy;
    a_load_four_after: assert property (frame_end |-> ##4 load_pulse)
        else $error("load pulse not four cycles after frame end");
    a_load_has_cause: assert property (load_pulse |-> $past(frame_end, 4))
        else $error("load pulse without frame end");
    a_load_ch_match: assert property (data_go |-> ##5 (load_pulse && load_ch == $past(ch_mask, 5)))
        else $error("load channels differ from write mask");
    a_frame_after_data: assert property (data_go |=> frame_end)
        else $error("no frame end after data write");
    a_dual_two_steps: assert property (data_go && ch_mask == 2'h3 |=> busy [*2] ##1 !busy)
        else $error("dual write not two sequential steps");
    a_single_one_step: assert property (data_go && ^ch_mask |=> busy ##1 !busy)
        else $error("single write not one step");
    a_busy_from_data: assert property ($rose(busy) |-> $past(wr_stb) && $past(op) == gocp_pkg::GOCP_OP_DATA)
        else $error("busy without data write");
    a_read_answer: assert property (rd_stb |-> ##[0:4] rvalid)
        else $error("read not answered");
    c_dual: cover property (data_go && ch_mask == 2'h3);
endmodule
`default_nettype wire

// ===== dac_gain_offset_correction_tb.sv
// testbench: apb master drives host end, device end faces it over the link
// assumes: zero-wait apb slave, corrected words visible on device outputs
`timescale 1ns/10ps
`default_nettype none
module dac_gain_offset_correction_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cal_enable, mode_sel, dac_load, last_err;
    logic [1:0] dac_load_ch;
    logic [15:0] dac_word [gocp_pkg::N_CH*gocp_pkg::N_DAC];
    logic [31:0] q;
    int errors = 0;
    int num_checks = 0;
    always #5 pclk = ~pclk;
    gocp_if gocp_if_inst ();
    gocp_host gocp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(gocp_if_inst),
        .cal_enable(cal_enable), .mode_sel(mode_sel));
    gocp_dev gocp_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(gocp_if_inst), .cal_enable(cal_enable),
        .mode_sel(mode_sel), .dac_word(dac_word), .dac_load(dac_load), .dac_load_ch(dac_load_ch));
    gocp_link_sva gocp_link_sva_inst (.pclk(pclk), .presetn(presetn), .wr_stb(gocp_if_inst.wr_stb),
        .op(gocp_if_inst.op), .ch_mask(gocp_if_inst.ch_mask), .rd_stb(gocp_if_inst.rd_stb),
        .frame_end(gocp_if_inst.frame_end), .busy(gocp_if_inst.busy), .rvalid(gocp_if_inst.rvalid),
        .load_pulse(gocp_if_inst.load_pulse), .load_ch(gocp_if_inst.load_ch));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("Error at %0t: apb access not answered", $time);
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // data word first, then the command that launches the link frame
    task automatic cmd(input logic [1:0] o, input logic [1:0] d, input logic [1:0] m, input logic s,
                       input logic [15:0] w);
        apb(1'b1, gocp_pkg::A_DATA, {16'h0, w}, q);
        apb(1'b1, gocp_pkg::A_CMD, {25'h0, s, m, d, o}, q);
        repeat (8) @(posedge pclk);
    endtask
    function automatic logic [15:0] exp_w(input logic [15:0] x, input logic [15:0] m, input logic [15:0] c);
        logic [33:0] s;
        s = ((34'(x) * (34'(m) + 34'h1)) >> 16) + 34'(c);
        if (s < 34'h8000) return 16'h0;
        s = s - 34'h8000;
        return (s > 34'hFFFF) ? 16'hFFFF : s[15:0];
    endfunction
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gocp_pkg::A_CTRL, 32'h0, q);
        check(q & 32'hFFFF, {16'h0, gocp_pkg::CTRL_RST});
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h0, 2'h1, 1'b0, 16'h1234);
        check(dac_word[0], 16'h1234);
        check({30'h0, dac_load_ch}, 32'h1);
        apb(1'b0, gocp_pkg::A_STAT, 32'h0, q);
        check(q & 32'h3, 32'h2);
        apb(1'b0, gocp_pkg::A_STAT, 32'h0, q);
        check(q & 32'h3, 32'h0);
        cmd(gocp_pkg::GOCP_OP_GAIN, 2'h0, 2'h1, 1'b0, 16'h7FFF);
        cmd(gocp_pkg::GOCP_OP_OFFS, 2'h0, 2'h1, 1'b0, 16'h8010);
        check(dac_word[0], 16'h1234);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h0, 2'h1, 1'b0, 16'h1234);
        check(dac_word[0], exp_w(16'h1234, 16'h7FFF, 16'h8010));
        cmd(gocp_pkg::GOCP_OP_READ, 2'h0, 2'h1, 1'b0, 16'h0);
        apb(1'b0, gocp_pkg::A_RDATA, 32'h0, q);
        check(q & 32'hFFFF, {16'h0, exp_w(16'h1234, 16'h7FFF, 16'h8010)});
        $display("test coefficients done");
        apb(1'b1, gocp_pkg::A_CTRL, 32'h3, q);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h0, 2'h1, 1'b0, 16'h1234);
        check(dac_word[0], 16'h1234);
        cmd(gocp_pkg::GOCP_OP_GAIN, 2'h1, 2'h1, 1'b1, 16'hBFFF);
        cmd(gocp_pkg::GOCP_OP_OFFS, 2'h1, 2'h2, 1'b1, 16'h8100);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h1, 2'h3, 1'b0, 16'h4000);
        check(dac_word[1], exp_w(16'h4000, 16'hBFFF, 16'h8000));
        check(dac_word[5], exp_w(16'h4000, 16'hFFFF, 16'h8100));
        $display("test modes done");
        cmd(gocp_pkg::GOCP_OP_OFFS, 2'h1, 2'h1, 1'b1, 16'hFFFF);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h1, 2'h1, 1'b0, 16'hFFFF);
        check(dac_word[1], 16'hFFFF);
        check(dac_word[5], exp_w(16'h4000, 16'hFFFF, 16'h8100));
        cmd(gocp_pkg::GOCP_OP_OFFS, 2'h1, 2'h1, 1'b1, 16'h0000);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h1, 2'h1, 1'b0, 16'h0010);
        check(dac_word[1], 16'h0000);
        apb(1'b1, gocp_pkg::A_CTRL, 32'h2, q);
        cmd(gocp_pkg::GOCP_OP_DATA, 2'h1, 2'h3, 1'b0, 16'hABCD);
        check(dac_word[1], 16'hABCD);
        check(dac_word[5], 16'hABCD);
        apb(1'b0, 12'h020, 32'h0, q);
        check({31'h0, last_err}, 32'h1);
        $display("test saturation and bypass done");
        summarize();
    end
endmodule
`default_nettype wire
